// [nac_alu.v]
`timescale 1ns/1ps
`include "nac_alu_defs.vh"

module nac_alu (
  input wire CORE_CLK,
  input wire RST,
  input wire INSTR_VALID,
  input wire [7:0] INSTR_BYTE0,
  input wire [7:0] INSTR_BYTE1,
  output wire INSTR_READY,
  output wire [3:0] WORK_NIBBLE,
  output wire CARRY_BIT,
  output wire ZERO_BIT,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP
);

  reg [3:0] work_nibble_reg;
  reg [3:0] work_nibble_next;
  reg [3:0] aux_nibble_reg;
  reg [3:0] aux_nibble_next;
  reg carry_bit_reg;
  reg carry_bit_next;
  reg zero_bit_reg;
  reg zero_bit_next;
  reg [1:0] memory_bank_sel_reg;
  reg [7:0] pointer_pair_low_reg;
  reg busy_reg;
  reg ready_reg;
  reg [7:0] op_hold_reg;
  reg [7:0] arg_hold_reg;
  reg [3:0] ram [0:1023];

  reg bus_wr_pend_reg;
  reg [11:0] bus_wr_addr_reg;
  reg bus_wr_ram_reg;
  reg [31:0] hrdata_reg;
  reg hreadyout_reg;
  reg bus_wr_csr_reg;
  reg hresp_reg;

  reg mem_we;
  reg [3:0] mem_wd;
  reg [4:0] sum;

  wire accept;
  wire two_byte;
  wire exec_go;
  wire [7:0] exec_op;
  wire [7:0] exec_arg;
  wire direct_mode;
  wire [9:0] mem_addr;
  wire [3:0] mem_rd;
  wire [1:0] bit_sel;
  wire bus_go;
  wire [31:0] status_word;

  // Five-bit sum so the carry out of bit 3 is kept
  function [4:0] add5;
    input [3:0] a;
    input [3:0] b;
    input c;
    begin
      add5 = {1'b0, a} + {1'b0, b} + {4'h0, c};
    end
  endfunction

  // Valid while ready is low is ignored, so the decoder must hold its offer
  assign accept = INSTR_VALID && ready_reg;
  assign two_byte = (INSTR_BYTE0[7:4] == `NAC_PREFIX_HI);
  // A one-byte instruction executes on its accept edge, a two-byte one an edge later
  assign exec_go = (accept && !two_byte) || busy_reg;
  assign exec_op = busy_reg ? op_hold_reg : INSTR_BYTE0;
  assign exec_arg = busy_reg ? arg_hold_reg : INSTR_BYTE1;
  // Sum-immediate carries no address; every other held opcode addresses directly
  assign direct_mode = busy_reg && (exec_op != `NAC_OP_SUM_IMMEDIATE);
  assign mem_addr = direct_mode ? {memory_bank_sel_reg, exec_arg} : {memory_bank_sel_reg, pointer_pair_low_reg};
  assign mem_rd = ram[mem_addr];
  assign bit_sel = exec_op[1:0];

  always @* begin
    work_nibble_next = work_nibble_reg;
    aux_nibble_next = aux_nibble_reg;
    carry_bit_next = carry_bit_reg;
    zero_bit_next = zero_bit_reg;
    mem_we = 1'b0;
    mem_wd = mem_rd;
    sum = 5'h00;
    if (exec_go) begin
      case (exec_op)
        `NAC_OP_ZERO_WORK: begin
          work_nibble_next = 4'h0;
          zero_bit_next = 1'b1;
        end
        `NAC_OP_CARRY_CLEAR: begin
          carry_bit_next = 1'b0;
        end
        `NAC_OP_CARRY_SET: begin
          carry_bit_next = 1'b1;
        end
        `NAC_OP_COMPLEMENT: begin
          work_nibble_next = ~work_nibble_reg;
          zero_bit_next = (work_nibble_reg == 4'hf);
        end
        `NAC_OP_INCREMENT_WORK: begin
          sum = add5(work_nibble_reg, 4'h1, 1'b0);
          work_nibble_next = sum[3:0];
          carry_bit_next = sum[4];
          zero_bit_next = (sum[3:0] == 4'h0);
        end
        `NAC_OP_DECREMENT_WORK: begin
          // Decrement as add of 1111: carry set means no borrow
          sum = add5(work_nibble_reg, 4'hf, 1'b0);
          work_nibble_next = sum[3:0];
          carry_bit_next = sum[4];
          zero_bit_next = (sum[3:0] == 4'h0);
        end
        `NAC_OP_ROTATE_RIGHT: begin
          work_nibble_next = {carry_bit_reg, work_nibble_reg[3:1]};
          carry_bit_next = work_nibble_reg[0];
        end
        `NAC_OP_ROTATE_LEFT: begin
          work_nibble_next = {work_nibble_reg[2:0], carry_bit_reg};
          carry_bit_next = work_nibble_reg[3];
          zero_bit_next = ({work_nibble_reg[2:0], carry_bit_reg} == 4'h0);
        end
        `NAC_OP_COPY_WORK_TO_AUX: begin
          aux_nibble_next = work_nibble_reg;
        end
        `NAC_OP_COPY_AUX_TO_WORK: begin
          work_nibble_next = aux_nibble_reg;
          zero_bit_next = (aux_nibble_reg == 4'h0);
        end
        `NAC_OP_SWAP_WORK_AUX: begin
          work_nibble_next = aux_nibble_reg;
          aux_nibble_next = work_nibble_reg;
        end
        `NAC_OP_INCREMENT_MEM, `NAC_OP_INCREMENT_DIRECT: begin
          sum = add5(mem_rd, 4'h1, 1'b0);
          mem_we = 1'b1;
          mem_wd = sum[3:0];
          carry_bit_next = sum[4];
          zero_bit_next = (sum[3:0] == 4'h0);
        end
        `NAC_OP_DECREMENT_MEM, `NAC_OP_DECREMENT_DIRECT: begin
          sum = add5(mem_rd, 4'hf, 1'b0);
          mem_we = 1'b1;
          mem_wd = sum[3:0];
          carry_bit_next = sum[4];
          zero_bit_next = (sum[3:0] == 4'h0);
        end
        `NAC_OP_SUM_MEM, `NAC_OP_SUM_DIRECT: begin
          sum = add5(work_nibble_reg, mem_rd, 1'b0);
          work_nibble_next = sum[3:0];
          carry_bit_next = sum[4];
          zero_bit_next = (sum[3:0] == 4'h0);
        end
        `NAC_OP_SUM_MEM_CARRY: begin
          sum = add5(work_nibble_reg, mem_rd, carry_bit_reg);
          work_nibble_next = sum[3:0];
          carry_bit_next = sum[4];
          zero_bit_next = (sum[3:0] == 4'h0);
        end
        `NAC_OP_MINUS_BORROW: begin
          // Memory plus inverted accumulator plus carry: carry clear means a borrow occurred
          sum = add5(mem_rd, ~work_nibble_reg, carry_bit_reg);
          work_nibble_next = sum[3:0];
          carry_bit_next = sum[4];
          zero_bit_next = (sum[3:0] == 4'h0);
        end
        `NAC_OP_SUM_IMMEDIATE: begin
          // Second byte must carry the immediate tag; anything else is ignored
          if (exec_arg[7:4] == `NAC_IMM_TAG) begin
            sum = add5(work_nibble_reg, exec_arg[3:0], 1'b0);
            work_nibble_next = sum[3:0];
            zero_bit_next = (sum[3:0] == 4'h0);
          end
        end
        `NAC_OP_CONJ_WORK: begin
          work_nibble_next = work_nibble_reg & mem_rd;
          zero_bit_next = ((work_nibble_reg & mem_rd) == 4'h0);
        end
        `NAC_OP_OR_WORK: begin
          work_nibble_next = work_nibble_reg | mem_rd;
          zero_bit_next = ((work_nibble_reg | mem_rd) == 4'h0);
        end
        `NAC_OP_XOR_WORK: begin
          work_nibble_next = work_nibble_reg ^ mem_rd;
          zero_bit_next = ((work_nibble_reg ^ mem_rd) == 4'h0);
        end
        `NAC_OP_CONJ_MEM: begin
          mem_we = 1'b1;
          mem_wd = work_nibble_reg & mem_rd;
          zero_bit_next = ((work_nibble_reg & mem_rd) == 4'h0);
        end
        `NAC_OP_OR_MEM: begin
          mem_we = 1'b1;
          mem_wd = work_nibble_reg | mem_rd;
          zero_bit_next = ((work_nibble_reg | mem_rd) == 4'h0);
        end
        default: begin
          // Only the set-bit and clear-bit groups decode here; other opcodes execute as no-ops
          if (exec_op[7:2] == `NAC_OP_SET_BIT_HI) begin
            mem_we = 1'b1;
            mem_wd = mem_rd | (4'h1 << bit_sel);
          end else if (exec_op[7:2] == `NAC_OP_CLEAR_BIT_HI) begin
            mem_we = 1'b1;
            mem_wd = mem_rd & ~(4'h1 << bit_sel);
            zero_bit_next = ((mem_rd & ~(4'h1 << bit_sel)) == 4'h0);
          end
        end
      endcase
    end
  end

  always @(posedge CORE_CLK) begin
    if (RST) begin
      work_nibble_reg <= `NAC_RST_NIBBLE;
      aux_nibble_reg <= `NAC_RST_NIBBLE;
      carry_bit_reg <= 1'b0;
      zero_bit_reg <= 1'b0;
      busy_reg <= 1'b0;
      ready_reg <= 1'b1;
      op_hold_reg <= 8'h00;
      arg_hold_reg <= 8'h00;
    end else begin
      work_nibble_reg <= work_nibble_next;
      aux_nibble_reg <= aux_nibble_next;
      carry_bit_reg <= carry_bit_next;
      zero_bit_reg <= zero_bit_next;
      // Ready drops for the execute cycle of a two-byte instruction
      if (accept && two_byte) begin
        busy_reg <= 1'b1;
        ready_reg <= 1'b0;
        op_hold_reg <= INSTR_BYTE0;
        arg_hold_reg <= INSTR_BYTE1;
      end else begin
        busy_reg <= 1'b0;
        ready_reg <= 1'b1;
      end
    end
  end

  // Instruction write wins over a bus write to RAM in the same cycle
  // RAM has no reset; software must load it before use
  always @(posedge CORE_CLK) begin
    if (mem_we) begin
      ram[mem_addr] <= mem_wd;
    end else if (bus_wr_pend_reg && bus_wr_ram_reg) begin
      ram[bus_wr_addr_reg[11:2]] <= HWDATA[3:0];
    end
  end

  assign bus_go = HSEL && HREADY && HTRANS[1];
  assign status_word = {22'h000000, zero_bit_reg, carry_bit_reg, aux_nibble_reg, work_nibble_reg};

  always @(posedge CORE_CLK) begin
    if (RST) begin
      bus_wr_pend_reg <= 1'b0;
      bus_wr_addr_reg <= 12'h000;
      bus_wr_ram_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      bus_wr_csr_reg <= 1'b0;
      hresp_reg <= 1'b0;
      memory_bank_sel_reg <= `NAC_RST_BANK;
      pointer_pair_low_reg <= `NAC_RST_POINTER;
    end else begin
      hreadyout_reg <= 1'b1;
      // Every transfer completes with an OKAY response
      hresp_reg <= 1'b0;
      bus_wr_pend_reg <= bus_go && HWRITE;
      if (bus_go) begin
        bus_wr_addr_reg <= HADDR[11:0];
        bus_wr_ram_reg <= (HADDR[31:12] == `NAC_RAM_PAGE);
        bus_wr_csr_reg <= (HADDR[31:12] == `NAC_REG_PAGE);
      end
      // Read data is fetched in the address phase so the slave needs no wait state
      hrdata_reg <= 32'h00000000;
      if (bus_go && !HWRITE) begin
        if (HADDR[31:12] == `NAC_RAM_PAGE) begin
          hrdata_reg <= {28'h0000000, ram[HADDR[11:2]]};
        end else if (HADDR[31:12] == `NAC_REG_PAGE) begin
          case (HADDR[11:0])
            `NAC_ADDR_BANK: hrdata_reg <= {30'h00000000, memory_bank_sel_reg};
            `NAC_ADDR_POINTER: hrdata_reg <= {24'h000000, pointer_pair_low_reg};
            `NAC_ADDR_STATUS: hrdata_reg <= status_word;
            default: hrdata_reg <= 32'h00000000;
          endcase
        end
      end
      // Only the register page decodes, so other pages cannot alias the bank
      if (bus_wr_pend_reg && bus_wr_csr_reg) begin
        case (bus_wr_addr_reg)
          `NAC_ADDR_BANK: memory_bank_sel_reg <= HWDATA[1:0];
          `NAC_ADDR_POINTER: pointer_pair_low_reg <= HWDATA[7:0];
          default: memory_bank_sel_reg <= memory_bank_sel_reg;
        endcase
      end
    end
  end

  assign INSTR_READY = ready_reg;
  assign WORK_NIBBLE = work_nibble_reg;
  assign CARRY_BIT = carry_bit_reg;
  assign ZERO_BIT = zero_bit_reg;
  assign HRDATA = hrdata_reg;
  assign HREADYOUT = hreadyout_reg;
  assign HRESP = hresp_reg;

endmodule

// [nac_alu_defs.vh]
`ifndef NAC_ALU_DEFS_VH
`define NAC_ALU_DEFS_VH

// Bus map, byte addresses
`define NAC_ADDR_BANK 12'h000
`define NAC_ADDR_POINTER 12'h004
`define NAC_ADDR_STATUS 12'h008
`define NAC_RAM_PAGE 20'h00001
`define NAC_REG_PAGE 20'h00000

// Status word layout
`define NAC_ST_WORK_LSB 0
`define NAC_ST_AUX_LSB 4
`define NAC_ST_CARRY_BIT 8
`define NAC_ST_ZERO_BIT 9

// Reset values
`define NAC_RST_BANK 2'h0
`define NAC_RST_POINTER 8'h00
`define NAC_RST_NIBBLE 4'h0

// One-byte opcodes
`define NAC_OP_ZERO_WORK 8'h80
`define NAC_OP_CARRY_CLEAR 8'h1e
`define NAC_OP_CARRY_SET 8'h1f
`define NAC_OP_COMPLEMENT 8'h18
`define NAC_OP_INCREMENT_WORK 8'h14
`define NAC_OP_DECREMENT_WORK 8'h24
`define NAC_OP_ROTATE_RIGHT 8'h10
`define NAC_OP_ROTATE_LEFT 8'h01
`define NAC_OP_COPY_WORK_TO_AUX 8'h45
`define NAC_OP_COPY_AUX_TO_WORK 8'h46
`define NAC_OP_SWAP_WORK_AUX 8'h44
`define NAC_OP_INCREMENT_MEM 8'h12
`define NAC_OP_DECREMENT_MEM 8'h22
`define NAC_OP_SUM_MEM 8'h06
`define NAC_OP_SUM_MEM_CARRY 8'h02
`define NAC_OP_MINUS_BORROW 8'h17
`define NAC_OP_CONJ_WORK 8'h07
`define NAC_OP_OR_WORK 8'h05
`define NAC_OP_XOR_WORK 8'h15
`define NAC_OP_CONJ_MEM 8'h03
`define NAC_OP_OR_MEM 8'h04
`define NAC_OP_SET_BIT_HI 6'h03
`define NAC_OP_CLEAR_BIT_HI 6'h0b

// Two-byte opcodes: first byte, immediate high nibble
`define NAC_PREFIX_HI 4'hc
`define NAC_OP_SUM_IMMEDIATE 8'hc2
`define NAC_OP_INCREMENT_DIRECT 8'hc7
`define NAC_OP_DECREMENT_DIRECT 8'hc3
`define NAC_OP_SUM_DIRECT 8'hc9
`define NAC_IMM_TAG 4'hf

`endif

// [nac_alu_props.sv]
`timescale 1ns/1ps
module nac_alu_props (
  input wire CORE_CLK,
  input wire RST,
  input wire INSTR_VALID,
  input wire [7:0] INSTR_BYTE0,
  input wire [7:0] INSTR_BYTE1,
  input wire INSTR_READY,
  input wire [3:0] WORK_NIBBLE,
  input wire CARRY_BIT,
  input wire ZERO_BIT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire acc = INSTR_VALID && INSTR_READY;

  AST_RDY_TWO: assert property (acc && INSTR_BYTE0[7:4] == 4'hc |=> !INSTR_READY ##1 INSTR_READY)
    else $error("ready not low for exactly one cycle");
  AST_ZERO: assert property (acc && INSTR_BYTE0 == 8'h80 |=> !WORK_NIBBLE && ZERO_BIT && $stable(CARRY_BIT))
    else $error("zero-work result wrong");
  AST_CLR: assert property (acc && INSTR_BYTE0 == 8'h1e |=> !CARRY_BIT)
    else $error("carry not cleared");
  AST_SET: assert property (acc && INSTR_BYTE0 == 8'h1f |=> CARRY_BIT)
    else $error("carry not set");
  AST_INC: assert property (acc && INSTR_BYTE0 == 8'h14 |=>
    {CARRY_BIT, WORK_NIBBLE} == $past(WORK_NIBBLE) + 5'h1 && ZERO_BIT == (WORK_NIBBLE == 4'h0))
    else $error("increment result wrong");
  AST_ROR: assert property (acc && INSTR_BYTE0 == 8'h10 |=>
    WORK_NIBBLE == {$past(CARRY_BIT), $past(WORK_NIBBLE[3:1])} && CARRY_BIT == $past(WORK_NIBBLE[0])
    && $stable(ZERO_BIT)) else $error("rotate right wrong");
  AST_ROL: assert property (acc && INSTR_BYTE0 == 8'h01 |=>
    WORK_NIBBLE == {$past(WORK_NIBBLE[2:0]), $past(CARRY_BIT)} && CARRY_BIT == $past(WORK_NIBBLE[3])
    && ZERO_BIT == (WORK_NIBBLE == 4'h0)) else $error("rotate left wrong");
  AST_DAA: assert property (acc && {INSTR_BYTE0, INSTR_BYTE1} == 16'hc2f6 |=> ##1
    WORK_NIBBLE == $past(WORK_NIBBLE, 2) + 4'h6 && CARRY_BIT == $past(CARRY_BIT, 2))
    else $error("add six wrong");
  AST_DAS: assert property (acc && {INSTR_BYTE0, INSTR_BYTE1} == 16'hc2fa |=> ##1
    WORK_NIBBLE == $past(WORK_NIBBLE, 2) + 4'ha && CARRY_BIT == $past(CARRY_BIT, 2))
    else $error("add ten wrong");
endmodule

bind nac_alu nac_alu_props u_nac_alu_props (
  .CORE_CLK(CORE_CLK),
  .RST(RST),
  .INSTR_VALID(INSTR_VALID),
  .INSTR_BYTE0(INSTR_BYTE0),
  .INSTR_BYTE1(INSTR_BYTE1),
  .INSTR_READY(INSTR_READY),
  .WORK_NIBBLE(WORK_NIBBLE),
  .CARRY_BIT(CARRY_BIT),
  .ZERO_BIT(ZERO_BIT)
);

// [nac_dec_model.sv]
`timescale 1ns/1ps
module nac_dec_model (
  input logic clk,
  input logic rst,
  input logic ready,
  output logic valid,
  output logic [7:0] b0,
  output logic [7:0] b1
);
  logic [15:0] q[$];
  initial begin
    valid = 0;
    b0 = 0;
    b1 = 0;
  end
  // Idle lanes toggle so a stale opcode never looks like a held one
  always @(posedge clk) begin
    if (rst) begin
      valid <= 0;
    end else begin
      if (valid && ready) q.delete(0);
      valid <= q.size() != 0;
      if (q.size() != 0) {b0, b1} <= q[0];
      else {b0, b1} <= ~{b0, b1};
    end
  end
endmodule

// [nibble_accumulator_alu_tb.sv]
`timescale 1ns/1ps
module nibble_accumulator_alu_tb;
  logic CORE_CLK = 0, RST = 1, HSEL = 0, HWRITE = 0;
  logic [31:0] HADDR = 0, HWDATA = 0;
  logic [1:0] HTRANS = 0;
  wire INSTR_VALID, INSTR_READY, CARRY_BIT, ZERO_BIT, HREADYOUT, HRESP;
  wire [7:0] INSTR_BYTE0, INSTR_BYTE1;
  wire [3:0] WORK_NIBBLE;
  wire [31:0] HRDATA;
  int err_total = 0, n_tests = 0, w, a, c, z, bk, pt, ram[1024];
  logic [15:0] tbl[36] = '{'h8000, 'h1e00, 'h1f00, 'h1800, 'h1400, 'h2400, 'h1000, 'h0100, 'h4500, 'h4600, 'h4400,
    'h1200, 'h2200, 'h0c00, 'h0d00, 'h0e00, 'h0f00, 'h2c00, 'h2d00, 'h2e00, 'h2f00, 'h0600, 'h0200,
    'h1700, 'h0700, 'h0500, 'h1500, 'h0300, 'h0400, 'hc2f6, 'hc2fa, 'hc2f9, 'hc253, 'hc700, 'hc300, 'hc900};

  always #5 CORE_CLK = ~CORE_CLK;

  nac_dec_model u_nac_dec_model (.clk(CORE_CLK), .rst(RST), .ready(INSTR_READY), .valid(INSTR_VALID),
    .b0(INSTR_BYTE0), .b1(INSTR_BYTE1));
  nac_alu u_nac_alu (.CORE_CLK(CORE_CLK), .RST(RST), .INSTR_VALID(INSTR_VALID), .INSTR_BYTE0(INSTR_BYTE0),
    .INSTR_BYTE1(INSTR_BYTE1), .INSTR_READY(INSTR_READY), .WORK_NIBBLE(WORK_NIBBLE), .CARRY_BIT(CARRY_BIT),
    .ZERO_BIT(ZERO_BIT), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask

  // Ready and read data are taken just before the edge, where registers have settled
  task automatic wt(output logic [31:0] d);
    int k;
    logic r;
    k = 0;
    do begin
      @(negedge CORE_CLK);
      r = HREADYOUT;
      d = HRDATA;
      @(posedge CORE_CLK);
      k++;
    end while (r !== 1'b1 && k < 50);
    if (r !== 1'b1) begin
      err_total++;
      give_verdict();
    end
  endtask

  task automatic ahb(logic wr, logic [31:0] ad, logic [31:0] wd, output logic [31:0] d);
    HSEL <= 1;
    HTRANS <= 2'h2;
    HADDR <= ad;
    HWRITE <= wr;
    wt(d);
    HTRANS <= 2'h0;
    HSEL <= 0;
    HWDATA <= wd;
    wt(d);
  endtask

  task automatic wr(logic [31:0] ad, logic [31:0] wd);
    logic [31:0] d;
    ahb(1, ad, wd, d);
  endtask

  task automatic rdc(logic [31:0] ad, logic [31:0] e, string nm);
    logic [31:0] d;
    ahb(0, ad, 0, d);
    chk(nm, d, e);
    chk("resp", HRESP, 0);
  endtask

  function automatic int ra(int v);
    return 'h1000 + 4 * (bk * 256 + v);
  endfunction

  function automatic void up(int s, int sc);
    w = s % 16;
    z = (w == 0);
    if (sc) c = s / 16;
  endfunction

  function automatic void ms(int ix, int s, int sc);
    ram[ix] = s % 16;
    z = (ram[ix] == 0);
    if (sc) c = s / 16;
  endfunction

  function automatic void ex(logic [15:0] ins);
    int o, ix, m, s;
    o = ins[15:8];
    ix = bk * 256 + (o > 'hc2 ? ins[7:0] : pt);
    m = ram[ix];
    case (o)
      'h80: up(0, 0);
      'h1e: c = 0;
      'h1f: c = 1;
      'h18: up(15 - w, 0);
      'h14: up(w + 1, 1);
      'h24: up(w + 15, 1);
      'h10: begin s = c * 8 + w / 2; c = w % 2; w = s; end
      'h01: begin s = w * 2 % 16 + c; c = w / 8; up(s, 0); end
      'h45: a = w;
      'h46: up(a, 0);
      'h44: begin s = a; a = w; w = s; end
      'h12, 'hc7: ms(ix, m + 1, 1);
      'h22, 'hc3: ms(ix, m + 15, 1);
      'h06, 'hc9: up(w + m, 1);
      'h02: up(w + m + c, 1);
      'h17: up(m + 15 - w + c, 1);
      'h07: up(w & m, 0);
      'h05: up(w | m, 0);
      'h15: up(w ^ m, 0);
      'h03: ms(ix, w & m, 0);
      'h04: ms(ix, w | m, 0);
      'h0c, 'h0d, 'h0e, 'h0f: ram[ix] = m | (1 << o % 4);
      'h2c, 'h2d, 'h2e, 'h2f: ms(ix, m & ~(1 << o % 4), 0);
      'hc2: if (ins[7:4] == 15) up(w + ins[3:0], 0);
      default: ;
    endcase
  endfunction

  initial begin
    logic [15:0] i0, i1;
    int i, e, k;
    logic r;
    void'($urandom(74672));
    repeat (6) @(posedge CORE_CLK);
    RST <= 0;
    @(posedge CORE_CLK);
    {w, a, c, z, bk, pt} = 0;
    rdc('h0, 0, "bank");
    rdc('h4, 0, "pointer");
    rdc('h8, 0, "status");
    wr('hc, 'h3ff);
    rdc('hc, 0, "unmapped");
    wr('h2000, 'h3);
    rdc('h0, 0, "alias");
    // Each pass issues the next opcode in table order and a random one back to back
    for (i = 0; i < 300; i++) begin
      bk = $urandom % 4;
      pt = $urandom % 256;
      e = pt ^ 'h5a;
      ram[bk * 256 + pt] = $urandom % 16;
      ram[bk * 256 + e] = $urandom % 16;
      wr('h0, bk);
      wr('h4, pt);
      wr(ra(pt), ram[bk * 256 + pt]);
      wr(ra(e), ram[bk * 256 + e]);
      i0 = tbl[i % 36];
      i1 = tbl[$urandom % 36];
      if (i0[15:8] > 'hc2) i0[7:0] = e;
      if (i1[15:8] > 'hc2) i1[7:0] = e;
      u_nac_dec_model.q.push_back(i0);
      u_nac_dec_model.q.push_back(i1);
      ex(i0);
      ex(i1);
      k = 0;
      do begin
        @(negedge CORE_CLK);
        r = u_nac_dec_model.q.size() == 0 && !INSTR_VALID && INSTR_READY;
        @(posedge CORE_CLK);
        k++;
      end while (!r && k < 50);
      if (!r) begin
        err_total++;
        give_verdict();
      end
      chk("work", WORK_NIBBLE, w);
      chk("flags", {ZERO_BIT, CARRY_BIT}, z * 2 + c);
      rdc('h8, z * 512 + c * 256 + a * 16 + w, "status");
      rdc(ra(pt), ram[bk * 256 + pt], "ram_ptr");
      rdc(ra(e), ram[bk * 256 + e], "ram_dir");
    end
    give_verdict();
  end
endmodule
